// [hdl/flbsc_bus_cycle.sv]
// one write or read cycle on the flash chip-enable/write-enable/output-enable pins
// assumes the caller keeps reset/power-down high while a cycle runs; abort drops it
`timescale 1ns/1ps
module flbsc_bus_cycle import flbsc_pkg::*; #(
    parameter int ADDR_W = 20,
    parameter int WE_PULSE_CYC = 4,
    parameter int RD_CYC = READ_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic isWrite,
    input wire logic abort,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wrData,
    output logic ready,
    output logic done,
    output logic [7:0] rdData,
    output logic [ADDR_W-1:0] flashAddr,
    output logic [7:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [7:0] flashDqIn,
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN
);
    flbsc_bus_state_type bstate_q;
    logic [7:0] cnt_q;
    logic write_q;
    logic [7:0] dqMeta_q;
    logic [7:0] dqSync_q;

    assign ready = (bstate_q == B_IDLE) && !abort;

    // data pins come from another domain: two flops first
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dqMeta_q <= 8'h00;
            dqSync_q <= 8'h00;
        end else begin
            dqMeta_q <= flashDqIn;
            dqSync_q <= dqMeta_q;
        end
    end

    // cycle sequencing and strobe timing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bstate_q <= B_IDLE;
            cnt_q <= 8'h00;
            write_q <= 1'b0;
            done <= 1'b0;
            rdData <= 8'h00;
        end else begin
            done <= 1'b0;
            if (abort) begin
                bstate_q <= B_IDLE;
            end else begin
                unique case (bstate_q)
                    B_IDLE: if (start) begin
                        write_q <= isWrite;
                        bstate_q <= B_SETUP;
                    end
                    B_SETUP: begin
                        cnt_q <= 8'h00;
                        bstate_q <= B_STROBE;
                    end
                    B_STROBE: begin
                        cnt_q <= cnt_q + 8'h01;
                        if (write_q && cnt_q == 8'(WE_PULSE_CYC - 1)) begin
                            bstate_q <= B_RELEASE;
                        end
                        // access time plus the two synchroniser stages
                        if (!write_q && cnt_q == 8'(RD_CYC + 2)) begin
                            rdData <= dqSync_q;
                            bstate_q <= B_RELEASE;
                        end
                    end
                    B_RELEASE: begin
                        done <= 1'b1;
                        bstate_q <= B_IDLE;
                    end
                endcase
            end
        end
    end

    // pin drive; data held one cycle past the rising write strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flashAddr <= '0;
            flashDqOut <= 8'h00;
            flashDqOe <= 1'b0;
            flashCeN <= 1'b1;
            flashWeN <= 1'b1;
            flashOeN <= 1'b1;
        end else if (abort) begin
            flashDqOe <= 1'b0;
            flashCeN <= 1'b1;
            flashWeN <= 1'b1;
            flashOeN <= 1'b1;
        end else begin
            if (bstate_q == B_IDLE && start) begin
                flashAddr <= addr;
                flashDqOut <= wrData;
                flashDqOe <= isWrite;
                flashCeN <= 1'b0;
            end
            if (bstate_q == B_SETUP) begin
                flashWeN <= !write_q;
                flashOeN <= write_q;
            end
            if (bstate_q == B_STROBE && bstate_q != B_IDLE && cnt_q == 8'(WE_PULSE_CYC - 1)
                && write_q) begin
                flashWeN <= 1'b1;
            end
            if (bstate_q == B_STROBE && !write_q && cnt_q == 8'(RD_CYC + 2)) begin
                flashOeN <= 1'b1;
            end
            if (bstate_q == B_RELEASE) begin
                flashCeN <= 1'b1;
                flashDqOe <= 1'b0;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_WE_UNDER_CE: assert property (!flashWeN |-> !flashCeN)
        else $error("write strobe low without chip enable");
    AST_WE_WIDTH: assert property ($fell(flashWeN) |-> !flashWeN [*4])
        else $error("write strobe pulse too short");
endmodule

// [hdl/flbsc_ctrl.sv]
// host controller that clears flash block lock-bits and does single byte cycles
// assumes an AXI4-Lite master on the register side and an external switch for the
// unlock high voltage on the reset/power-down pin, steered by unlockVoltEn
//
// Function
// - setup write then execution write
// - poll machine-ready bit until set
// - erase/clear error triggers clear-status command
// - aborted clear leaves bits undetermined, repeat
// - issue read-array before expecting array data
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module flbsc_ctrl import flbsc_pkg::*; #(
    parameter int ADDR_W = 20,
    parameter int WE_PULSE_CYC = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [ADDR_W-1:0] flashAddr,
    output logic [7:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [7:0] flashDqIn,
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN,
    output logic flashRpN,
    output logic unlockVoltEn
);
    flbsc_state_type state_q;
    logic [AXI_AW-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic wrFire, wrHit;
    logic [31:0] rdMux;
    logic rdHit;
    logic powerDown_q, hvReq_q;
    logic [31:0] codes_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] wByte_q, rByte_q, opStatus_q;
    logic done_q, undetermined_q, issued_q;
    logic [7:0] wakeCnt_q;
    logic goClear, goWrite, goRead, canStart;
    logic busStart, busWrite, busReady, busDone;
    logic [7:0] busData, busRdData;
    logic clearOp, pollReady;

    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // write fires once address and data are both held
    assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wrHit = awAddr_q == OFS_CTRL || awAddr_q == OFS_CODES || awAddr_q == OFS_ADDR
                   || awAddr_q == OFS_WDATA;
    assign goClear = wrFire && awAddr_q == OFS_CTRL && wStrb_q[0] && wData_q[CTRL_GO_CLEAR];
    assign goWrite = wrFire && awAddr_q == OFS_CTRL && wStrb_q[0] && wData_q[CTRL_GO_WRITE];
    assign goRead = wrFire && awAddr_q == OFS_CTRL && wStrb_q[0] && wData_q[CTRL_GO_READ];
    // starts while powered down or waking are dropped
    assign canStart = !powerDown_q && wakeCnt_q == 8'h00 && state_q == S_IDLE;

    // axi write channels, address and data taken in either order
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awAddr_q <= '0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? RESP_OKAY : RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // software registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            powerDown_q <= 1'b0;
            hvReq_q <= 1'b0;
            codes_q <= RST_CODES;
            addr_q <= RST_ADDR;
            wByte_q <= RST_BYTE;
        end else if (wrFire) begin
            if (awAddr_q == OFS_CTRL && wStrb_q[0]) begin
                powerDown_q <= wData_q[CTRL_POWERDOWN];
                hvReq_q <= wData_q[CTRL_UNLOCK_HV];
            end
            if (awAddr_q == OFS_CODES) begin
                codes_q <= mergeStrb(codes_q, wData_q, wStrb_q);
            end
            if (awAddr_q == OFS_ADDR) begin
                addr_q <= ADDR_W'(mergeStrb(32'(addr_q), wData_q, wStrb_q));
            end
            if (awAddr_q == OFS_WDATA && wStrb_q[0]) begin
                wByte_q <= wData_q[7:0];
            end
        end
    end

    // read decode; flag fields of the status byte only mean something after a clear
    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL: rdMux = {27'h0, hvReq_q, powerDown_q, 3'h0};
            OFS_CODES: rdMux = codes_q;
            OFS_ADDR: rdMux = 32'(addr_q);
            OFS_WDATA: rdMux = {24'h0, wByte_q};
            OFS_STATUS: begin
                rdMux[7:0] = opStatus_q;
                rdMux[STAT_BUSY] = !canStart;
                rdMux[STAT_DONE] = done_q;
                rdMux[STAT_ERASE_CLR_ERR] = opStatus_q[SR_ERASE_CLEAR_ERROR];
                rdMux[STAT_UNDETERMINED] = undetermined_q;
                rdMux[STAT_PROTECT] = opStatus_q[SR_PROTECT_ABORT];
                rdMux[STAT_SUPPLY_LOW] = opStatus_q[SR_PROG_SUPPLY_LOW];
                rdMux[STAT_SEQ_ERR] = opStatus_q[SR_ERASE_CLEAR_ERROR]
                                      && opStatus_q[SR_WRITE_SETLOCK_ERROR];
            end
            OFS_RDATA: rdMux = {24'h0, rByte_q};
            default: rdHit = 1'b0;
        endcase
    end

    // axi read channel, answer one cycle after the address
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdHit ? RESP_OKAY : RESP_DECERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // reset pin low keeps flash idle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flashRpN <= 1'b1;
            wakeCnt_q <= 8'h00;
        end else begin
            flashRpN <= !powerDown_q;
            if (powerDown_q) begin
                wakeCnt_q <= 8'(RP_WAKE_CYC);
            end else if (wakeCnt_q != 8'h00) begin
                wakeCnt_q <= wakeCnt_q - 8'h01;
            end
        end
    end

    // one bus request per state, except the poll state, which repeats its read until ready
    assign clearOp = state_q == S_SETUP || state_q == S_CONFIRM || state_q == S_POLL;
    assign busStart = !issued_q && busReady && state_q != S_IDLE && !powerDown_q;
    assign busWrite = state_q != S_POLL && state_q != S_SINGLE_RD;
    assign pollReady = state_q == S_POLL && busDone && busRdData[SR_MACHINE_READY];
    always_comb begin
        busData = wByte_q;
        unique case (state_q)
            S_SETUP: busData = codes_q[7:0];
            S_CONFIRM: busData = codes_q[15:8];
            S_CLRSTAT: busData = codes_q[23:16];
            S_READARR: busData = codes_q[31:24];
            default: busData = wByte_q;
        endcase
    end

    // operation sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            issued_q <= 1'b0;
        end else if (powerDown_q && state_q != S_IDLE) begin
            state_q <= S_IDLE;
            issued_q <= 1'b0;
        end else begin
            if (busStart) begin
                issued_q <= 1'b1;
            end
            if (busDone) begin
                issued_q <= 1'b0;
            end
            unique case (state_q)
                S_IDLE: begin
                    if (goClear && canStart) begin
                        state_q <= S_SETUP;
                    end else if (goWrite && canStart) begin
                        state_q <= S_SINGLE_WR;
                    end else if (goRead && canStart) begin
                        state_q <= S_SINGLE_RD;
                    end
                end
                S_SETUP: if (busDone) state_q <= S_CONFIRM;
                S_CONFIRM: if (busDone) state_q <= S_POLL;
                S_POLL: begin
                    if (pollReady) begin
                        state_q <= busRdData[SR_ERASE_CLEAR_ERROR] ? S_CLRSTAT : S_READARR;
                    end
                end
                S_CLRSTAT: if (busDone) state_q <= S_READARR;
                S_READARR: if (busDone) state_q <= S_IDLE;
                S_SINGLE_WR: if (busDone) state_q <= S_IDLE;
                S_SINGLE_RD: if (busDone) state_q <= S_IDLE;
            endcase
        end
    end

    // results and sticky flags
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            opStatus_q <= 8'h00;
            rByte_q <= 8'h00;
            done_q <= 1'b0;
            undetermined_q <= 1'b0;
            unlockVoltEn <= 1'b0;
        end else begin
            // status byte is what the poll returns
            if (pollReady) begin
                opStatus_q <= busRdData;
            end
            if (state_q == S_SINGLE_RD && busDone) begin
                rByte_q <= busRdData;
            end
            if ((goClear || goWrite || goRead) && canStart) begin
                done_q <= 1'b0;
            end
            if ((state_q == S_READARR || state_q == S_SINGLE_WR || state_q == S_SINGLE_RD)
                && busDone && !powerDown_q) begin
                done_q <= 1'b1;
            end
            if (pollReady && !busRdData[SR_ERASE_CLEAR_ERROR]) begin
                undetermined_q <= 1'b0;
            end
            if (powerDown_q && (state_q == S_CONFIRM || state_q == S_POLL)) begin
                undetermined_q <= 1'b1;
            end
            unlockVoltEn <= hvReq_q && clearOp && !powerDown_q;
        end
    end

    flbsc_bus_cycle #(
        .ADDR_W(ADDR_W),
        .WE_PULSE_CYC(WE_PULSE_CYC),
        .RD_CYC(READ_CYC)
    ) u_bus (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(busStart),
        .isWrite(busWrite),
        .abort(powerDown_q),
        .addr(addr_q),
        .wrData(busData),
        .ready(busReady),
        .done(busDone),
        .rdData(busRdData),
        .flashAddr(flashAddr),
        .flashDqOut(flashDqOut),
        .flashDqOe(flashDqOe),
        .flashDqIn(flashDqIn),
        .flashCeN(flashCeN),
        .flashWeN(flashWeN),
        .flashOeN(flashOeN)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_CONFIRM_AFTER_SETUP: assert property ($rose(state_q == S_CONFIRM) |-> $past(state_q) == S_SETUP)
        else $error("execution write without setup write");
    AST_SETUP_CODE: assert property (state_q == S_SETUP && busStart |-> busWrite && busData == codes_q[7:0])
        else $error("setup write carries wrong code");
    AST_POLL_AGAIN: assert property (state_q == S_POLL && busDone && !busRdData[SR_MACHINE_READY] && !powerDown_q |=> state_q == S_POLL)
        else $error("poll left before machine ready");
    AST_ERR_CLRSTAT: assert property (pollReady && busRdData[SR_ERASE_CLEAR_ERROR] && !powerDown_q |=> state_q == S_CLRSTAT ##[1:60] state_q == S_READARR)
        else $error("error not followed by clear status then read array");
    AST_READ_ARRAY_LAST: assert property ($fell(clearOp) && !powerDown_q |-> state_q == S_CLRSTAT || state_q == S_READARR)
        else $error("clear ended without read array");
    AST_ABORT_UNDET: assert property (powerDown_q && state_q == S_POLL |=> undetermined_q)
        else $error("aborted clear not flagged");
    AST_RP_QUIET: assert property (!flashRpN && $past(!flashRpN) |-> flashCeN && flashWeN && flashOeN)
        else $error("flash strobed while reset low");
    AST_WAKE_GAP: assert property ($rose(flashRpN) |-> flashCeN [*8])
        else $error("cycle started during wake time");
    AST_HV_ONLY_CLEAR: assert property (unlockVoltEn |-> $past(hvReq_q && clearOp))
        else $error("unlock voltage outside clear");

    COV_CLEAR_OK: cover property (pollReady && !busRdData[SR_ERASE_CLEAR_ERROR]);
    COV_CLEAR_ERR: cover property (state_q == S_CLRSTAT && busDone);
    COV_ABORT: cover property (powerDown_q && state_q == S_POLL);
    COV_SINGLE_RD: cover property (state_q == S_SINGLE_RD && busDone);
endmodule

// [inc/flbsc_pkg.sv]
// constants, register map and state type of the flash lock-bit clear controller
// assumes a 40 MHz system clock and an 8-bit asynchronous flash on the far side
package flbsc_pkg;
    // clock and pin timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int READ_ACCESS_NS = 130;
    localparam int RP_WAKE_NS = 600;
    localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_WAKE_CYC = (RP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // register bus
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CODES = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RDATA = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // control register fields
    localparam int CTRL_GO_CLEAR = 0;
    localparam int CTRL_GO_WRITE = 1;
    localparam int CTRL_GO_READ = 2;
    localparam int CTRL_POWERDOWN = 3;
    localparam int CTRL_UNLOCK_HV = 4;
    // status register fields of this controller
    localparam int STAT_BUSY = 8;
    localparam int STAT_DONE = 9;
    localparam int STAT_ERASE_CLR_ERR = 10;
    localparam int STAT_UNDETERMINED = 11;
    localparam int STAT_PROTECT = 12;
    localparam int STAT_SUPPLY_LOW = 13;
    localparam int STAT_SEQ_ERR = 14;
    // operation_status byte of the flash
    localparam int SR_MACHINE_READY = 7;
    localparam int SR_ERASE_SUSPENDED = 6;
    localparam int SR_ERASE_CLEAR_ERROR = 5;
    localparam int SR_WRITE_SETLOCK_ERROR = 4;
    localparam int SR_PROG_SUPPLY_LOW = 3;
    localparam int SR_WRITE_SUSPENDED = 2;
    localparam int SR_PROTECT_ABORT = 1;
    // reset values
    localparam logic [31:0] RST_CODES = 32'h0000_0000;
    localparam logic [19:0] RST_ADDR = 20'h00000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef enum {
        S_IDLE, S_SETUP, S_CONFIRM, S_POLL, S_CLRSTAT, S_READARR, S_SINGLE_WR, S_SINGLE_RD
    } flbsc_state_type;

    typedef enum {B_IDLE, B_SETUP, B_STROBE, B_RELEASE} flbsc_bus_state_type;
endpackage

// [sim/flbsc_flash_model.sv]
// behavioural flash: status byte, lock-bits, command modes
// assumes command codes shared with the bench; released dq is never left stale
`timescale 1ns/1ps
module flbsc_flash_model #(
    parameter logic [7:0] CSET = 8'h21, CEXE = 8'h22, CCLR = 8'h23, CARR = 8'h24
) (
    input wire logic [19:0] flashAddr,
    input wire logic [7:0] flashDqOut,
    input wire logic flashCeN,
    input wire logic flashWeN,
    input wire logic flashOeN,
    input wire logic flashDqOe,
    input wire logic flashRpN,
    // rail levels as plain qualifier bits
    input wire logic unlockVoltEn,
    input wire logic vppLow,
    input wire logic setMaster,
    input wire logic [1:0] busyReads,
    output logic [7:0] flashDqIn,
    output logic [3:0] locks
);
    logic [7:0] sr = 8'h80, lastQ = 8'h00, rdVal;
    logic statMode = 1'b0, armed = 1'b0, master = 1'b0;
    logic [1:0] busyCnt = 2'h0;
    logic [3:0] lockQ = 4'hF;
    assign locks = lockQ;
    always @(posedge setMaster) master <= 1'b1;
    // pin low clears status and mode
    always @(negedge flashRpN) begin
        sr <= 8'h80;
        statMode <= 1'b0;
        armed <= 1'b0;
        busyCnt <= 2'h0;
    end
    // command on write-enable rise, host driving dq
    always @(posedge flashWeN) if (!flashCeN && flashRpN && flashDqOe) begin
        statMode <= 1'b1;
        armed <= (flashDqOut == CSET);
        if (armed && flashDqOut == CEXE) begin
            if (vppLow) sr[5:3] <= 3'b101;
            else if (master && !unlockVoltEn) sr[5:1] <= 5'b10001;
            else lockQ <= 4'h0;
            busyCnt <= busyReads;
        end else if (armed) sr[5:4] <= 2'b11;
        else if (flashDqOut == CCLR) sr <= 8'h80;
        else if (flashDqOut == CARR) statMode <= 1'b0;
    end
    assign rdVal = statMode ? {busyCnt == 2'h0, sr[6:0]} : ~flashAddr[7:0];
    assign flashDqIn = (!flashCeN && !flashOeN && flashRpN) ? rdVal : ~lastQ;
    // slow answers: ready stays low for a few polls
    always @(posedge flashOeN) begin
        lastQ <= rdVal;
        if (statMode && busyCnt != 2'h0) busyCnt <= busyCnt - 2'h1;
    end
endmodule

// [sim/tb_top.sv]
// self-checking bench: AXI4-Lite master, queued checks, behavioural flash
// assumes the design answers every AXI request; a cycle ceiling cuts hangs
`timescale 1ns/1ps
module tb_top import flbsc_pkg::*;;
    localparam logic [7:0] CSET = 8'h21, CEXE = 8'h22, CCLR = 8'h23, CARR = 8'h24;
    logic clk = 1'b0, sys_rst = 1'b1, setMaster = 1'b0, vppLow = 1'b0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
    logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, flashDqOe, flashCeN, flashWeN, flashOeN, flashRpN, unlockVoltEn;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, flashDqOut, flashDqIn;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdLast;
    logic [3:0] s_axi_wstrb = 4'hF, locks;
    logic [1:0] busyReads = '0, s_axi_bresp, s_axi_rresp, bq[$];
    logic [19:0] flashAddr, rndAddr;
    logic [65:0] e, rq[$];
    // case fields: master, unlock, supply low, bad code, status byte, locks after
    logic [15:0] cases [4] = '{16'h2A8F, 16'h1B0F, 16'h8A2F, 16'hC800};
    int errCount = 0, nCompared = 0, cyc = 0, seed = 32'hCE3AA61F;
    flbsc_ctrl dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn, .flashCeN, .flashWeN,
        .flashOeN, .flashRpN, .unlockVoltEn);
    flbsc_flash_model #(.CSET(CSET), .CEXE(CEXE), .CCLR(CCLR), .CARR(CARR)) far (.flashAddr,
        .flashDqOut, .flashCeN, .flashWeN, .flashOeN, .flashDqOe, .flashRpN, .unlockVoltEn, .vppLow,
        .setMaster, .busyReads, .flashDqIn, .locks);
    initial forever #12.5 clk = ~clk;
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        nCompared++;
        if (s !== x) begin
            errCount++;
            $display("FAIL %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic endOfTest;
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ceiling well above the expected few hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errCount++;
            endOfTest();
        end
    end
    function automatic logic [31:0] statExp(input logic [7:0] s);
        statExp = {17'h0, s[5] & s[4], s[3], s[1], 1'b0, s[5], 2'b10, s};
    endfunction
    // one write or read; each valid dropped at the edge its ready was seen
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, m,
        input logic [1:0] r);
        @(posedge clk);
        if (w) bq.push_back(r);
        else rq.push_back({r, m, d & m});
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            rdLast = s_axi_rdata;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid));
        {s_axi_bready, s_axi_rready} <= 2'h0;
    endtask
    task automatic poll;
        do axi(1'b0, OFS_STATUS, '0, '0, RESP_OKAY);
        while (!rdLast[STAT_DONE] || rdLast[STAT_BUSY]);
    endtask
    // answers against the oldest queued expectation
    always @(posedge clk) if (s_axi_rvalid && s_axi_rready) begin
        e = rq.pop_front();
        check("rdata", s_axi_rdata & e[63:32], e[31:0]);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, e[65:64]});
    end
    always @(posedge clk) if (s_axi_bvalid && s_axi_bready)
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        axi(1'b0, OFS_CODES, RST_CODES, '1, RESP_OKAY);
        axi(1'b0, 8'h18, '0, '1, RESP_DECERR);
        axi(1'b1, 8'h1C, '0, '0, RESP_DECERR);
        rndAddr = 20'($random(seed));
        axi(1'b1, OFS_ADDR, {12'h000, rndAddr}, '0, RESP_OKAY);
        foreach (cases[i]) begin
            setMaster <= cases[i][15];
            vppLow <= cases[i][13];
            busyReads <= 2'($random(seed));
            axi(1'b1, OFS_CODES, {CARR, CCLR, cases[i][12] ? 8'h5A : CEXE, CSET}, '0, RESP_OKAY);
            axi(1'b1, OFS_CTRL, {27'h0, cases[i][14], 4'h1}, '0, RESP_OKAY);
            poll();
            axi(1'b0, OFS_STATUS, statExp(cases[i][11:4]), '1, RESP_OKAY);
            check("locks", {28'h0, locks}, {28'h0, cases[i][3:0]});
        end
        axi(1'b1, OFS_WDATA, {24'h0, CARR}, '0, RESP_OKAY);
        axi(1'b1, OFS_CTRL, 32'h2, '0, RESP_OKAY);
        poll();
        axi(1'b1, OFS_CTRL, 32'h4, '0, RESP_OKAY);
        poll();
        axi(1'b0, OFS_RDATA, {24'h0, ~rndAddr[7:0]}, '1, RESP_OKAY);
        // clear cut short by power-down while the poll is still busy
        busyReads <= 2'h3;
        axi(1'b1, OFS_CTRL, 32'h1, '0, RESP_OKAY);
        repeat (20) @(posedge clk);
        axi(1'b1, OFS_CTRL, 32'h8, '0, RESP_OKAY);
        repeat (2) @(posedge clk);
        check("rpN", {31'h0, flashRpN}, '0);
        axi(1'b1, OFS_CTRL, '0, '0, RESP_OKAY);
        axi(1'b0, OFS_STATUS, 32'h900, 32'h900, RESP_OKAY);
        endOfTest();
    end
endmodule
